/* common/brs_consts.svh */
// Timing figures and reset values for the boot and hibernate sequencer.
// Assumes a 200 MHz system clock; times are kept in microseconds, per-KB times in nanoseconds.
`ifndef BRS_CONSTS_SVH
`define BRS_CONSTS_SVH

`define BRS_CLK_MHZ          200
`define BRS_HW_WAKE_US       25000
`define BRS_ROM_XTAL_US      1100000
`define BRS_ROM_EXT_RAM_US   10300
`define BRS_ROM_EXT_FLASH_US 17300
`define BRS_LOAD_RAM_NS_KB   1700000
`define BRS_CHECK_FLASH_NS_KB 60000
`define BRS_HIB_WAKE_US      50000
`define BRS_HIB_PATCH_US     75000
`define BRS_HIB_CAL_US       200000
`define BRS_SYNC_RST_VAL     3'b000
`define BRS_SLOW_OSC_RST     1'b0
`define BRS_FAST_CLK_RST     1'b0

`endif

/* common/brs_pkg.sv */
// Types shared by the boot and hibernate sequencer.
// Assumes brs_consts.svh supplies the numeric constants.
package brs_pkg;

    // Sequencer stages
    typedef enum logic [2:0] {
        BRS_HOLD     = 3'b000,
        BRS_HW_WAKE  = 3'b001,
        BRS_ROM_INIT = 3'b010,
        BRS_APP_LOAD = 3'b011,
        BRS_RUN      = 3'b100,
        BRS_HIBER    = 3'b101,
        BRS_HIB_WAKE = 3'b110
    } brs_state_t;

    // Board and firmware options sampled by the sequencer
    typedef struct packed {
        logic        flash_variant;
        logic        ext_slow_clk;
        logic [10:0] image_kb;
    } brs_cfg_t;

    // Hibernate wake conditions
    typedef struct packed {
        logic calib_needed;
        logic patch_needed;
    } brs_wake_t;

    // Status seen by the rest of the chip
    typedef struct packed {
        brs_state_t  stage;
        logic        slow_osc_en;
        logic        fast_clk_en;
        logic        rtc_run;
        logic        boot_done;
    } brs_status_t;

endpackage

/* rtl/brs_sequencer.sv */
// Boot, reset and hibernate-wake sequencer of the wireless controller.
// Assumes external_reset_n is an asynchronous board pin; all other inputs
// are driven from logic on the 200 MHz clock.
//
// Functional notes
// RL1: Board holds external_reset_n low while supplies ramp.
// RL2: With external slow clock, reset released only once it is stable.
// RL3: Restart needs an external reset low pulse of at least 200 ms.
// RL4: With the high-value pulldown fitted, pulse may shrink to 100 us.
// RL5: Host calls host_stop_call before toggling reset; prefer software reset.
// RL6: Reset released at least 1 ms after both supplies are stable.
// RL7: Crystal boot: 25 ms hardware wake, then 1.1 s ROM initialisation.
// RL8: External slow clock: ROM init 10.3 ms RAM-only, 17.3 ms flash.
// RL9: Then 1.7 ms per KB load, or 0.06 ms per KB flash check.
// RL10: Hibernate wake takes 50 ms, or 200 ms when calibration runs.
// RL11: Hibernate wake stretches to 75 ms when a patch is fetched.
// RL12: Slow crystal oscillator stays enabled while hibernating.
// RL13: Slow clock feeds the RTC; fast clock feeds processor and radio.
// RL14: Supplied slow clock is within 150 ppm of nominal.
// RL15: External slow clock enters on the positive oscillator pin.
// RL16: Boot stages run strictly in order, each after the previous ends.
`include "brs_consts.svh"

module brs_sequencer
    import brs_pkg::*;
#(
    parameter int unsigned HW_WAKE_CYC   =
        `BRS_HW_WAKE_US * `BRS_CLK_MHZ,
    parameter int unsigned ROM_XTAL_CYC  =
        `BRS_ROM_XTAL_US * `BRS_CLK_MHZ,
    parameter int unsigned ROM_RAM_CYC   =
        `BRS_ROM_EXT_RAM_US * `BRS_CLK_MHZ,
    parameter int unsigned ROM_FLASH_CYC =
        `BRS_ROM_EXT_FLASH_US * `BRS_CLK_MHZ,
    parameter int unsigned LOAD_KB_CYC   =
        `BRS_LOAD_RAM_NS_KB * `BRS_CLK_MHZ / 1000,
    parameter int unsigned CHECK_KB_CYC  =
        `BRS_CHECK_FLASH_NS_KB * `BRS_CLK_MHZ / 1000,
    parameter int unsigned HIB_WAKE_CYC  =
        `BRS_HIB_WAKE_US * `BRS_CLK_MHZ,
    parameter int unsigned HIB_PATCH_CYC =
        `BRS_HIB_PATCH_US * `BRS_CLK_MHZ,
    parameter int unsigned HIB_CAL_CYC   =
        `BRS_HIB_CAL_US * `BRS_CLK_MHZ
)(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        external_reset_n,
    input  wire brs_cfg_t    cfg,
    input  wire logic        hibernate_req,
    input  wire logic        wake_req,
    input  wire brs_wake_t   wake_cond,
    output brs_status_t      status,
    output logic             stage_done
);

    // Reset pin synchroniser; only stage 2 and 3 are looked at
    logic [2:0]  rst_sync_q;
    logic        rst_pin_low_q;
    logic        rst_agree;
    logic        rst_assert;
    logic        rst_release;

    brs_state_t  state_q;
    brs_state_t  state_d;
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic [10:0] kb_left_q;
    logic [10:0] kb_left_d;
    brs_cfg_t    cfg_q;
    logic        slow_osc_en_q;
    logic        fast_clk_en_q;
    logic        rtc_run_q;
    logic        boot_done_q;
    logic        stage_done_q;

    // Pin synchroniser: three flops, change counts when stages 2 and 3 agree
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rst_sync_q    <= `BRS_SYNC_RST_VAL;
            rst_pin_low_q <= 1'b1;
        end
        else
        begin
            rst_sync_q    <= {rst_sync_q[1:0], external_reset_n};
            if (rst_agree)
                rst_pin_low_q <= ~rst_sync_q[2];
        end
    end

    assign rst_agree   = rst_sync_q[1] == rst_sync_q[2];
    // A low level seen at stages 2 and 3 together restarts; pulse length is the board's duty [RL3] [RL4]
    assign rst_assert  = rst_agree && !rst_sync_q[2];
    // Release marks supplies and slow clock as stable [RL1] [RL2] [RL6]
    assign rst_release = rst_agree && rst_sync_q[2] && rst_pin_low_q;

    // Stage lengths picked by continuous selection
    logic        timer_done;
    logic [31:0] rom_cyc;
    logic [31:0] kb_cyc;
    logic [31:0] hib_cyc;
    logic        no_image;

    assign timer_done = count_q == 32'h0000_0001;
    // Crystal settling dominates ROM init unless the clock is external
    assign rom_cyc = !cfg_q.ext_slow_clk ? 32'(ROM_XTAL_CYC)      // [RL7]
                   : cfg_q.flash_variant ? 32'(ROM_FLASH_CYC)     // [RL8]
                   : 32'(ROM_RAM_CYC);                            // [RL8]
    assign kb_cyc  = cfg_q.flash_variant ? 32'(CHECK_KB_CYC)      // [RL9]
                   : 32'(LOAD_KB_CYC);                            // [RL9]
    // Longest applicable extension wins when several conditions hold
    assign hib_cyc = wake_cond.calib_needed ? 32'(HIB_CAL_CYC)    // [RL10]
                   : wake_cond.patch_needed ? 32'(HIB_PATCH_CYC)  // [RL11]
                   : 32'(HIB_WAKE_CYC);                           // [RL10]
    assign no_image = cfg_q.image_kb == 11'h000;

    // Next-state logic; each stage starts only when the prior one ends
    always_comb
    begin
        state_d   = state_q;
        count_d   = count_q;
        kb_left_d = kb_left_q;
        unique case (state_q)
            BRS_HOLD:
            begin
                if (rst_release)
                begin
                    state_d = BRS_HW_WAKE;                        // [RL16]
                    count_d = 32'(HW_WAKE_CYC);                   // [RL7]
                end
            end
            BRS_HW_WAKE:
            begin
                count_d = count_q - 32'h0000_0001;
                if (timer_done)
                begin
                    state_d = BRS_ROM_INIT;                       // [RL16]
                    count_d = rom_cyc;
                end
            end
            BRS_ROM_INIT:
            begin
                count_d = count_q - 32'h0000_0001;
                if (timer_done)
                begin
                    state_d   = no_image ? BRS_RUN : BRS_APP_LOAD; // [RL16]
                    count_d   = kb_cyc;
                    kb_left_d = cfg_q.image_kb;
                end
            end
            BRS_APP_LOAD:
            begin
                // One per-KB slice at a time keeps the counter 32 bits wide
                count_d = count_q - 32'h0000_0001;
                if (timer_done)
                begin
                    kb_left_d = kb_left_q - 11'h001;              // [RL9]
                    count_d   = kb_cyc;
                    if (kb_left_q == 11'h001)
                        state_d = BRS_RUN;                        // [RL16]
                end
            end
            BRS_RUN:
            begin
                if (hibernate_req)
                    state_d = BRS_HIBER;
            end
            BRS_HIBER:
            begin
                if (wake_req)
                begin
                    state_d = BRS_HIB_WAKE;
                    count_d = hib_cyc;                    // [RL10] [RL11]
                end
            end
            BRS_HIB_WAKE:
            begin
                count_d = count_q - 32'h0000_0001;
                if (timer_done)
                begin
                    state_d   = no_image ? BRS_RUN : BRS_APP_LOAD;
                    count_d   = kb_cyc;
                    kb_left_d = cfg_q.image_kb;
                end
            end
            default:
            begin
                state_d = BRS_HOLD;
            end
        endcase
        if (rst_assert)
        begin
            state_d   = BRS_HOLD;
            count_d   = 32'h0000_0000;
            kb_left_d = 11'h000;
        end
    end

    // Sequencer registers
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q   <= BRS_HOLD;
            count_q   <= 32'h0000_0000;
            kb_left_q <= 11'h000;
        end
        else
        begin
            state_q   <= state_d;
            count_q   <= count_d;
            kb_left_q <= kb_left_d;
        end
    end

    // Options are latched at reset release so they cannot shift mid-boot
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            cfg_q <= '0;
        else if (state_q == BRS_HOLD)
            cfg_q <= cfg;
    end

    // Clock enables and status flags, all registered
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            slow_osc_en_q <= `BRS_SLOW_OSC_RST;
            fast_clk_en_q <= `BRS_FAST_CLK_RST;
            rtc_run_q     <= 1'b0;
            boot_done_q   <= 1'b0;
            stage_done_q  <= 1'b0;
        end
        else
        begin
            // Slow oscillator runs in every state but hold [RL12] [RL13]
            slow_osc_en_q <= state_d != BRS_HOLD;
            rtc_run_q     <= state_d != BRS_HOLD;                 // [RL13]
            // Fast clock off only while held or hibernating [RL13]
            fast_clk_en_q <= state_d != BRS_HOLD &&
                             state_d != BRS_HIBER;
            boot_done_q   <= state_d == BRS_RUN;
            stage_done_q  <= state_d != state_q && !rst_assert &&
                             state_q != BRS_HOLD;
        end
    end

    assign status = '{stage:       state_q,
                      slow_osc_en: slow_osc_en_q,
                      fast_clk_en: fast_clk_en_q,
                      rtc_run:     rtc_run_q,
                      boot_done:   boot_done_q};
    assign stage_done = stage_done_q;

endmodule

/* test/brs_seq_chk.sv */
// Checker for stage order, stage lengths and clock enables.
// Bound to brs_sequencer; sees only its ports.
module brs_seq_chk
    import brs_pkg::*;
#(
    parameter int unsigned HW_WAKE_CYC   = 20,
    parameter int unsigned ROM_XTAL_CYC  = 40,
    parameter int unsigned ROM_RAM_CYC   = 10,
    parameter int unsigned ROM_FLASH_CYC = 12
)(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        external_reset_n,
    input wire brs_cfg_t    cfg,
    input wire logic        hibernate_req,
    input wire logic        wake_req,
    input wire brs_wake_t   wake_cond,
    input wire brs_status_t status,
    input wire logic        stage_done
);
    timeunit 1ns;
    timeprecision 1ps;
    brs_state_t  prev_q;
    logic [31:0] len_q;
    // A pin reset back to hold is not a stage exit
    wire         moved = status.stage != prev_q && status.stage != BRS_HOLD;
    wire [31:0]  rom_n = !cfg.ext_slow_clk ? ROM_XTAL_CYC
                       : cfg.flash_variant ? ROM_FLASH_CYC : ROM_RAM_CYC;
    // Cycles spent in the present stage
    always_ff @(posedge clock or posedge reset)
        if (reset)
        begin
            prev_q <= BRS_HOLD;
            len_q  <= 32'h0;
        end
        else
        begin
            prev_q <= status.stage;
            len_q  <= (status.stage != prev_q) ? 32'h1 : len_q + 32'h1;
        end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    hw_order_a: assert property (
        moved && prev_q == BRS_HW_WAKE |-> status.stage == BRS_ROM_INIT)
        else $error("wrong stage after wake");
    rom_order_a: assert property (
        moved && prev_q == BRS_ROM_INIT
        |-> status.stage inside {BRS_APP_LOAD, BRS_RUN})
        else $error("wrong stage after rom");
    hw_len_a: assert property (
        moved && prev_q == BRS_HW_WAKE |-> len_q == HW_WAKE_CYC)
        else $error("wake length wrong");
    rom_len_a: assert property (
        moved && prev_q == BRS_ROM_INIT |-> len_q == rom_n)
        else $error("rom length wrong");
    hib_osc_a: assert property (
        status.stage == BRS_HIBER |-> status.slow_osc_en)
        else $error("slow osc off in hibernate");
    run_clk_a: assert property (
        status.stage == BRS_RUN |-> status.fast_clk_en && status.slow_osc_en)
        else $error("clocks off in run");
    run_done_a: assert property (
        status.boot_done == (status.stage == BRS_RUN))
        else $error("boot done mismatch");
    pin_hold_a: assert property (
        !external_reset_n [*8] |-> status.stage == BRS_HOLD)
        else $error("not held by pin");
    done_pulse_a: assert property (
        stage_done |=> !stage_done)
        else $error("stage done too long");
    // Pulse must mark every timed exit, never a start or a pin reset
    done_mark_a: assert property (
        stage_done == (moved && prev_q != BRS_HOLD))
        else $error("stage done not on exit");
    hib_order_a: assert property (
        moved && prev_q == BRS_HIB_WAKE
        |-> status.stage inside {BRS_APP_LOAD, BRS_RUN})
        else $error("wrong stage after hib wake");
endmodule
bind brs_sequencer brs_seq_chk #(
    .HW_WAKE_CYC(HW_WAKE_CYC), .ROM_XTAL_CYC(ROM_XTAL_CYC),
    .ROM_RAM_CYC(ROM_RAM_CYC), .ROM_FLASH_CYC(ROM_FLASH_CYC)
) chk_u (
    .clock(clock), .reset(reset), .external_reset_n(external_reset_n),
    .cfg(cfg), .hibernate_req(hibernate_req), .wake_req(wake_req),
    .wake_cond(wake_cond), .status(status), .stage_done(stage_done)
);

/* test/brs_rst_sup.sv */
// Board reset supervisor model driving the active-low reset pin.
// Assumes the bench clock; counts are scaled-down cycles.
module brs_rst_sup #(
    parameter int RAMP_CYC  = 30,
    parameter int PULSE_CYC = 20
)(
    input  wire logic clock,
    input  wire logic restart,
    output logic      external_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = RAMP_CYC;
    // Low through supply ramp and settling
    initial external_reset_n = 1'b0;
    // Restart pulse on every restart request, held low PULSE_CYC + 1 cycles
    always @(posedge clock)
        if (restart)
        begin
            external_reset_n <= 1'b0;
            cnt              <= PULSE_CYC;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
        else
            external_reset_n <= 1'b1;
endmodule

/* test/tb_top.sv */
// Bench for the boot sequencer with shortened stage counts.
// Assumes the supervisor model owns the board reset pin.
module tb_top
    import brs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HW = 20, RX = 40, RR = 10, RF = 12, LD = 5, CK = 3;
    localparam int HB = 8, HP = 10, HC = 16;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        restart = 1'b0;
    logic        external_reset_n;
    brs_cfg_t    cfg = '0;
    logic        hibernate_req = 1'b0;
    logic        wake_req = 1'b0;
    brs_wake_t   wake_cond = '0;
    brs_status_t status;
    logic        stage_done;
    int          mismatches = 0;
    int          compares = 0;
    initial forever #2.5 clock = ~clock;
    brs_rst_sup sup_u (.clock(clock), .restart(restart),
        .external_reset_n(external_reset_n));
    brs_sequencer #(.HW_WAKE_CYC(HW), .ROM_XTAL_CYC(RX), .ROM_RAM_CYC(RR),
        .ROM_FLASH_CYC(RF), .LOAD_KB_CYC(LD), .CHECK_KB_CYC(CK),
        .HIB_WAKE_CYC(HB), .HIB_PATCH_CYC(HP), .HIB_CAL_CYC(HC)) dut_u (
        .clock(clock), .reset(reset), .external_reset_n(external_reset_n),
        .cfg(cfg), .hibernate_req(hibernate_req), .wake_req(wake_req),
        .wake_cond(wake_cond), .status(status), .stage_done(stage_done));
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait; sampled on the falling edge once updates landed
    task automatic wait_st(brs_state_t s);
        int i;
        i = 0;
        while (status.stage !== s && i < 999)
        begin
            @(negedge clock);
            i++;
        end
    endtask
    task automatic meas(brs_state_t s, int n);
        int k;
        k = 0;
        wait_st(s);
        while (status.stage === s && k < 999)
        begin
            @(negedge clock);
            k++;
        end
        cmp(k, n);
    endtask
    task automatic t_boot(brs_cfg_t c, int rom, int app);
        @(posedge clock);
        cfg     <= c;
        restart <= 1'b1;
        @(posedge clock);
        restart <= 1'b0;
        meas(BRS_HW_WAKE, HW);
        meas(BRS_ROM_INIT, rom);
        if (app > 0)
            meas(BRS_APP_LOAD, app);
        cmp(status.stage, BRS_RUN);
        cmp(status.boot_done, 1'b1);
        $display("boot test done");
    endtask
    task automatic t_hib(brs_wake_t w, int n, int app);
        @(posedge clock);
        hibernate_req <= 1'b1;
        @(posedge clock);
        hibernate_req <= 1'b0;
        wait_st(BRS_HIBER);
        cmp(status.slow_osc_en, 1'b1);
        cmp(status.fast_clk_en, 1'b0);
        cmp(status.rtc_run, 1'b1);
        @(posedge clock);
        wake_cond <= w;
        wake_req  <= 1'b1;
        @(posedge clock);
        wake_req  <= 1'b0;
        meas(BRS_HIB_WAKE, n);
        // Wake re-runs the load or check when an image is present
        if (app > 0)
            meas(BRS_APP_LOAD, app);
        cmp(status.stage, BRS_RUN);
        $display("hibernate test done");
    endtask
    task automatic end_sim;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Whole run is well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        mismatches++;
        end_sim;
    end
    initial
    begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        t_boot('{1'b0, 1'b0, 11'h002}, RX, 2 * LD);
        t_boot('{1'b1, 1'b1, 11'h003}, RF, 3 * CK);
        t_boot('{1'b0, 1'b1, 11'h000}, RR, 0);
        t_hib('{1'b1, 1'b0}, HC, 0);
        t_hib('{1'b0, 1'b1}, HP, 0);
        t_hib('{1'b1, 1'b1}, HC, 0);
        t_hib('{1'b0, 1'b0}, HB, 0);
        t_boot('{1'b1, 1'b0, 11'h002}, RX, 2 * CK);
        t_hib('{1'b0, 1'b1}, HP, 2 * CK);
        end_sim;
    end
endmodule
